// >>> hw/vpic_top.v
// Vectored priority interrupt controller with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`include "vpic_regs.vh"
module vpic_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [117:0] src_event,
   input wire [4:0] ext_irq_pin,
   input wire [3:0] trap_event,
   input wire soft_hard_trap_event,
   input wire double_bit_error_event,
   input wire disi_active,
   input wire [2:0] cpu_priority_level,
   input wire cpu_priority_level_hi,
   input wire cpu_ack,
   output reg cpu_irq_req_q,
   output reg [7:0] pending_vector_number_q,
   output reg [3:0] new_cpu_priority_level_q,
   output reg [23:0] vector_addr_q,
   output reg irq_q
);
   // Register state
   reg [127:0] flag_q, flag_d;
   reg [127:0] en_q, en_d;
   reg [16*`VP_NPRIO_WORDS-1:0] prio_q, prio_d;
   reg [15:0] gc1_q, gc1_d;
   reg [15:0] gc2_q, gc2_d;
   reg [1:0] gc4_q, gc4_d;
   reg vhold_q;
   reg [2:0] ev_status_q, ev_status_d;
   reg [2:0] ev_mask_q;
   // Bus data-phase state
   reg wr_pend_q;
   reg rd_pend_q;
   reg [11:0] addr_q;

   wire addr_take;
   wire wr_now;
   wire [4:0] ext_event;
   wire [127:0] set_vec;
   wire [127:0] arb_valid;
   wire [383:0] arb_prio;
   wire found;
   wire [2:0] best_prio;
   wire [6:0] best_idx;
   wire forward;
   wire [6:0] flag_widx;
   wire [6:0] en_widx;
   wire [6:0] prio_widx;

   // Word index within a register bank, or all ones when outside it
   function [6:0] bank_index;
      input [11:0] addr;
      input [11:0] base;
      input [6:0] count;
      reg [9:0] idx;
      begin
         idx = addr[11:2] - base[11:2];
         if (addr >= base && idx < {3'b000, count})
            bank_index = idx[6:0];
         else
            bank_index = 7'h7F;
      end
   endfunction

   assign flag_widx = bank_index(addr_q, `VP_OFS_FLAG, 7'h08);
   assign en_widx = bank_index(addr_q, `VP_OFS_ENABLE, 7'h08);
   assign prio_widx = bank_index(addr_q, `VP_OFS_PRIO, 7'h1E);

   // Accept an address phase only while our own data phase is done
   assign addr_take = hsel & hready & htrans[1];
   assign wr_now = wr_pend_q;

   vpic_edge #(
      .N(5)
   ) u_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(ext_irq_pin),
      .neg_edge(gc2_q[4:0]),
      .edge_event(ext_event)
   );

   // External pins feed the flags of their own request numbers
   assign set_vec = {10'h000, src_event} | ({127'h0, ext_event[0]}) | ({107'h0, ext_event[1], 20'h00000})
      | ({98'h0, ext_event[2], 29'h0}) | ({73'h0, ext_event[4], ext_event[3], 53'h0});

   // Per-source valid and priority slots for the tree
   genvar g;
   generate
      for (g = 0; g < 128; g = g + 1)
      begin : gen_slot
         assign arb_valid[g] = flag_q[g] & en_q[g];
         if (g < 4 * `VP_NPRIO_WORDS)
         begin : gen_p
            assign arb_prio[3*g+:3] = prio_q[16*(g/4)+4*(g%4)+:3];
         end
         else
         begin : gen_z
            assign arb_prio[3*g+:3] = 3'h0;
         end
      end
   endgenerate

   vpic_arbiter u_arb (
      .req_valid(arb_valid),
      .req_prio(arb_prio),
      .found(found),
      .best_prio(best_prio),
      .best_idx(best_idx)
   );

   // level seven or upper bit blocks
   assign forward = found & gc2_q[`VP_GC2_GLOBAL_EN] & ~cpu_priority_level_hi
      & (cpu_priority_level != `VP_CPU_LEVEL_OFF) & (best_prio > cpu_priority_level);

   // Next register values; hardware sets win over software writes
   integer i;
   always @*
   begin
      flag_d = flag_q;
      en_d = en_q;
      prio_d = prio_q;
      gc1_d = gc1_q;
      gc2_d = gc2_q;
      gc4_d = gc4_q;
      ev_status_d = ev_status_q;
      if (wr_now)
      begin
         for (i = 0; i < `VP_NFLAG_WORDS; i = i + 1)
         begin
            if (flag_widx == i[6:0])
               flag_d[16*i+:16] = hwdata[15:0];
            if (en_widx == i[6:0])
               en_d[16*i+:16] = hwdata[15:0];
         end
         for (i = 0; i < `VP_NPRIO_WORDS; i = i + 1)
         begin
            if (prio_widx == i[6:0])
               prio_d[16*i+:16] = hwdata[15:0] & `VP_PRIO_MASK;
         end
         if (addr_q == `VP_OFS_GC1)
            gc1_d = hwdata[15:0] & `VP_GC1_MASK;
         if (addr_q == `VP_OFS_GC2)
            gc2_d = hwdata[15:0] & `VP_GC2_WMASK;
         if (addr_q == `VP_OFS_GC4)
            gc4_d = gc4_q & hwdata[1:0];
         if (addr_q == `VP_OFS_IRQ_STATUS)
            ev_status_d = ev_status_q & ~hwdata[2:0];
      end
      flag_d = (flag_d | set_vec) & `VP_IMPL_MASK;
      en_d = en_d & `VP_IMPL_MASK;
      gc1_d[`VP_GC1_TRAP_LSB+:4] = gc1_d[`VP_GC1_TRAP_LSB+:4] | trap_event;
      gc4_d = gc4_d | {double_bit_error_event, soft_hard_trap_event};
      ev_status_d = ev_status_d | {(|ext_event), (|trap_event) | soft_hard_trap_event | double_bit_error_event,
         forward & ~cpu_irq_req_q};
   end

   // Read mux for the data phase
   function [15:0] read_word;
      input [11:0] addr;
      input [6:0] fidx;
      input [6:0] eidx;
      input [6:0] pidx;
      input [127:0] flags;
      input [127:0] ens;
      input [16*`VP_NPRIO_WORDS-1:0] prios;
      input [15:0] st_gc1;
      input [15:0] st_gc2;
      input [1:0] st_gc4;
      input [15:0] st_pvs;
      input [2:0] st_ev;
      input [2:0] st_mask;
      begin
         read_word = 16'h0000;
         if (fidx < 7'h08)
            read_word = flags[16*fidx+:16];
         else if (eidx < 7'h08)
            read_word = ens[16*eidx+:16];
         else if (pidx < 7'h1E)
            read_word = prios[16*pidx+:16];
         else if (addr == `VP_OFS_GC1)
            read_word = st_gc1;
         else if (addr == `VP_OFS_GC2)
            read_word = st_gc2;
         else if (addr == `VP_OFS_GC4)
            read_word = {14'h0000, st_gc4};
         else if (addr == `VP_OFS_PVS)
            read_word = st_pvs;
         else if (addr == `VP_OFS_IRQ_STATUS)
            read_word = {13'h0000, st_ev};
         else if (addr == `VP_OFS_IRQ_MASK)
            read_word = {13'h0000, st_mask};
      end
   endfunction

   // Bus slave: writes have no wait, reads one wait so prior writes land first
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 12'h000;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hresp <= 1'b0;
         wr_pend_q <= addr_take & hwrite;
         rd_pend_q <= addr_take & ~hwrite;
         if (addr_take)
            addr_q <= {haddr[11:2], 2'b00};
         if (addr_take & ~hwrite)
            hreadyout <= 1'b0;
         else
            hreadyout <= 1'b1;
         // Unmapped reads return zero with OKAY
         if (rd_pend_q)
            hrdata <= {16'h0000, read_word(addr_q, flag_widx, en_widx, prio_widx, flag_q, en_q, prio_q,
               gc1_q, {gc2_q[15], disi_active, gc2_q[13:0]}, gc4_q,
               {cpu_irq_req_q, 1'b0, vhold_q, 1'b0, new_cpu_priority_level_q, pending_vector_number_q},
               ev_status_q, ev_mask_q)};
      end
   end

   // Control and per-source storage
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flag_q <= 128'h0;
         en_q <= 128'h0;
         prio_q <= {16*`VP_NPRIO_WORDS{1'b0}};
         gc1_q <= `VP_GC1_RST;
         gc2_q <= `VP_GC2_RST;
         gc4_q <= 2'b00;
         vhold_q <= 1'b0;
         ev_status_q <= 3'b000;
         ev_mask_q <= 3'b000;
      end
      else
      begin
         flag_q <= flag_d;
         en_q <= en_d;
         prio_q <= prio_d;
         gc1_q <= gc1_d;
         gc2_q <= gc2_d;
         gc4_q <= gc4_d;
         ev_status_q <= ev_status_d;
         if (wr_now && addr_q == `VP_OFS_PVS)
            vhold_q <= hwdata[`VP_PVS_VHOLD];
         if (wr_now && addr_q == `VP_OFS_IRQ_MASK)
            ev_mask_q <= hwdata[2:0];
      end
   end

   // Vector latch; with hold set, it only moves on a core acknowledge
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cpu_irq_req_q <= 1'b0;
         pending_vector_number_q <= 8'h00;
         new_cpu_priority_level_q <= 4'h0;
         vector_addr_q <= 24'h000000;
         irq_q <= 1'b0;
      end
      else
      begin
         cpu_irq_req_q <= forward;
         irq_q <= |(ev_status_d & ev_mask_q);
         if (!vhold_q || cpu_ack)
         begin
            pending_vector_number_q <= found ? ({1'b0, best_idx} + `VP_VEC_NUM_BASE) : 8'h00;
            new_cpu_priority_level_q <= found ? {1'b0, best_prio} : 4'h0;
            vector_addr_q <= found ? (`VP_IVT_BASE + {16'h0000, best_idx, 1'b0}) : 24'h000000;
         end
      end
   end
endmodule

// >>> hw/vpic_regs.vh
// Constants for the vectored priority interrupt controller
`ifndef VPIC_REGS_VH
`define VPIC_REGS_VH

`define VP_NSRC 118
`define VP_NFLAG_WORDS 8
`define VP_NPRIO_WORDS 30
// Implemented request numbers; holes are the unlisted sources
`define VP_IMPL_MASK 128'h003F_E46F_CFFE_23FF_FC6F_FFF3_FFDF_FFFF
`define VP_PRIO_MASK 16'h7777
`define VP_VEC_NUM_BASE 8'h08
`define VP_IVT_BASE 24'h000014

// Register byte offsets
`define VP_OFS_GC1 12'h000
`define VP_OFS_GC2 12'h004
`define VP_OFS_GC4 12'h008
`define VP_OFS_PVS 12'h00C
`define VP_OFS_IRQ_STATUS 12'h020
`define VP_OFS_IRQ_MASK 12'h024
`define VP_OFS_FLAG 12'h040
`define VP_OFS_ENABLE 12'h080
`define VP_OFS_PRIO 12'h100

// Field positions
`define VP_GC1_NEST_DIS 15
`define VP_GC1_TRAP_LSB 1
`define VP_GC1_MASK 16'h801E
`define VP_GC2_GLOBAL_EN 15
`define VP_GC2_DISI 14
`define VP_GC2_SWTRAP 13
`define VP_GC2_ALT_TABLE 8
`define VP_GC2_WMASK 16'hA11F
`define VP_PVS_REQ 15
`define VP_PVS_VHOLD 13

// Reset values and the core level that blocks all requests
`define VP_GC1_RST 16'h0000
`define VP_GC2_RST 16'h8000
`define VP_CPU_LEVEL_OFF 3'h7

`endif

// >>> hw/vpic_edge.v
// Edge detectors for the external interrupt request pins
module vpic_edge #(
   parameter N = 5
)(
   input wire hclk,
   input wire hresetn,
   input wire [N-1:0] pin,
   input wire [N-1:0] neg_edge,
   output wire [N-1:0] edge_event
);
   reg [N-1:0] prev_q;
   reg primed_q;

   // Previous pin level; no event before first sample is known
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prev_q <= {N{1'b0}};
         primed_q <= 1'b0;
      end
      else
      begin
         prev_q <= pin;
         primed_q <= 1'b1;
      end
   end

   // Polarity chosen per pin
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1)
      begin : gen_edge
         assign edge_event[g] = primed_q & (neg_edge[g] ? (prev_q[g] & ~pin[g]) : (~prev_q[g] & pin[g]));
      end
   endgenerate
endmodule

// >>> hw/vpic_arbiter.v
// Priority tournament tree over 128 request slots
module vpic_arbiter (
   input wire [127:0] req_valid,
   input wire [383:0] req_prio,
   output wire found,
   output wire [2:0] best_prio,
   output wire [6:0] best_idx
);
   // Heap layout: node k has children 2k and 2k+1, leaves at 128..255
   wire [255:1] node_v;
   wire [3*256-1:3] node_p;
   wire [7*256-1:7] node_i;

   genvar g;
   generate
      for (g = 0; g < 128; g = g + 1)
      begin : gen_leaf
         wire [31:0] idx_w;
         // Leaf index as a net, since a genvar cannot be part-selected
         assign idx_w = g;
         assign node_v[128+g] = req_valid[g];
         assign node_p[3*(128+g)+:3] = req_prio[3*g+:3];
         assign node_i[7*(128+g)+:7] = idx_w[6:0];
      end
      for (g = 1; g < 128; g = g + 1)
      begin : gen_node
         wire take_right;
         assign take_right = node_v[2*g+1] & (~node_v[2*g] | (node_p[3*(2*g+1)+:3] > node_p[3*(2*g)+:3]));
         assign node_v[g] = node_v[2*g] | node_v[2*g+1];
         assign node_p[3*g+:3] = take_right ? node_p[3*(2*g+1)+:3] : node_p[3*(2*g)+:3];
         assign node_i[7*g+:7] = take_right ? node_i[7*(2*g+1)+:7] : node_i[7*(2*g)+:7];
      end
   endgenerate

   assign found = node_v[1];
   assign best_prio = node_p[5:3];
   assign best_idx = node_i[13:7];
endmodule

// >>> tb/vpic_top_properties.sv
// Port-level checker for the interrupt controller
`include "vpic_regs.vh"
module vpic_top_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [2:0] cpu_priority_level,
   input wire logic cpu_priority_level_hi,
   input wire logic cpu_irq_req_q,
   input wire logic [7:0] pending_vector_number_q,
   input wire logic [3:0] new_cpu_priority_level_q,
   input wire logic [23:0] vector_addr_q
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [127:0] IMPL = `VP_IMPL_MASK;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Core side: blocking levels and latch consistency
   a_hi_blocks: assert property (cpu_priority_level_hi |=> !cpu_irq_req_q)
      else $error("request forwarded while upper level bit set");
   a_seven_blocks: assert property (cpu_priority_level == 3'h7 |=> !cpu_irq_req_q)
      else $error("request forwarded at level seven");
   a_vec_addr_map: assert property (pending_vector_number_q != 8'h00 |->
      vector_addr_q == 24'h000014 + {15'h0, pending_vector_number_q - 8'h08, 1'b0})
      else $error("vector address does not match vector number");
   a_hole_never: assert property (pending_vector_number_q != 8'h00 |->
      IMPL[pending_vector_number_q - 8'h08])
      else $error("unlisted request selected");
   a_level_none: assert property (pending_vector_number_q == 8'h00 |-> new_cpu_priority_level_q == 4'h0)
      else $error("level latched without a vector");
   // Bus side: one wait state on reads, none on writes, never an error
   a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state not exactly one cycle");
   a_write_ready: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled the bus");
   a_resp_okay: assert property (!hresp)
      else $error("error response seen");
   c_req: cover property ($rose(cpu_irq_req_q));
   c_read: cover property (hsel && htrans[1] && !hwrite);
   c_hi: cover property (cpu_priority_level_hi);
endmodule

bind vpic_top vpic_top_properties u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
   .hresp, .cpu_priority_level, .cpu_priority_level_hi, .cpu_irq_req_q, .pending_vector_number_q,
   .new_cpu_priority_level_q, .vector_addr_q);

// >>> tb/vpic_core_model.sv
// Behavioural processor core on the controller's request side
module vpic_core_model #(
   parameter int ACK_WAIT = 2
)(
   input logic hclk,
   input logic hresetn,
   input logic irq_req,
   input logic [2:0] want_level,
   input logic want_hi,
   output logic [2:0] level_q,
   output logic level_hi_q,
   output logic ack_q
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;
   // Level lags the bench by one edge; a slow core acks only after ACK_WAIT cycles
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         level_q <= 3'h0;
         level_hi_q <= 1'b0;
         ack_q <= 1'b0;
         cnt_q <= 0;
      end
      else
      begin
         level_q <= want_level;
         level_hi_q <= want_hi;
         ack_q <= irq_req && cnt_q == ACK_WAIT;
         cnt_q <= irq_req ? cnt_q + 1 : 0;
      end
   end
endmodule

// >>> tb/test_vectored_priority_interrupt_controller.sv
// Register and core-side tests for the interrupt controller
`include "vpic_regs.vh"
module test_vectored_priority_interrupt_controller;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
   logic [1:0] htrans = 2'b00;
   logic [117:0] src_event = '0;
   logic [4:0] ext_irq_pin = 5'h00;
   logic [3:0] trap_event = 4'h0, new_cpu_priority_level_q;
   logic soft_hard_trap_event = 1'b0, double_bit_error_event = 1'b0, want_hi = 1'b0, disi = 1'b0;
   logic [2:0] cpu_priority_level, want_level = 3'h0;
   logic cpu_priority_level_hi, cpu_ack, cpu_irq_req_q, irq_q;
   logic [7:0] pending_vector_number_q;
   logic [23:0] vector_addr_q;
   int failures = 0, comparisons = 0;
   assign hready = hreadyout;
   always #10 hclk = ~hclk;
   vpic_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .src_event, .ext_irq_pin, .trap_event, .soft_hard_trap_event,
      .double_bit_error_event, .disi_active(disi), .cpu_priority_level, .cpu_priority_level_hi,
      .cpu_ack, .cpu_irq_req_q, .pending_vector_number_q, .new_cpu_priority_level_q, .vector_addr_q, .irq_q);
   vpic_core_model core_m (.hclk, .hresetn, .irq_req(cpu_irq_req_q), .want_level, .want_hi,
      .level_q(cpu_priority_level), .level_hi_q(cpu_priority_level_hi), .ack_q(cpu_ack));
   task automatic close_out;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string w, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask
   // One single AHB transfer; address held until hready, read data taken at the last edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {20'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rdata = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdchk(input string w, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(w, e, rdata);
   endtask
   task automatic pause;
      repeat (3) @(posedge hclk);
   endtask
   // Single-cycle event pulse on one request line
   task automatic fire(input int k);
      src_event[k] <= 1'b1;
      @(posedge hclk);
      src_event <= '0;
      pause();
   endtask
   task automatic core(input int n, input logic [2:0] p);
      chk("core", {1'b1, 8'(n + 8), 1'b0, p, 24'h14 + 24'(2 * n)},
         {cpu_irq_req_q, pending_vector_number_q, new_cpu_priority_level_q, vector_addr_q});
   endtask
   // Hang guard, generous against a few hundred cycles of tests
   initial
   begin
      repeat (5000) @(posedge hclk);
      failures++;
      close_out();
   end
   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk("ctl2", `VP_OFS_GC2, 32'h8000);
      rdchk("ctl1", `VP_OFS_GC1, 32'h0);
      rdchk("pend", `VP_OFS_PVS, 32'h0);
      wr(12'h200, 32'hFFFF);
      rdchk("unmapped", 12'h200, 32'h0);
      wr(`VP_OFS_PRIO, 32'hFFFFFFFF);
      rdchk("prio0", `VP_OFS_PRIO, 32'h7777);
      wr(`VP_OFS_ENABLE + 12'h1C, 32'hFFFF);
      rdchk("en7", `VP_OFS_ENABLE + 12'h1C, 32'h003F);
      wr(`VP_OFS_ENABLE + 12'h4, 32'hFFFF);
      rdchk("en1", `VP_OFS_ENABLE + 12'h4, 32'hFFDF);
      $display("test storage done");
      wr(`VP_OFS_PRIO, 32'h5000);
      wr(`VP_OFS_ENABLE, 32'h0008);
      fire(3);
      core(3, 3'h5);
      rdchk("flag0", `VP_OFS_FLAG, 32'h0008);
      rdchk("pend", `VP_OFS_PVS, 32'h850B);
      fire(4);
      rdchk("flag0", `VP_OFS_FLAG, 32'h0018);
      wr(`VP_OFS_FLAG, 32'h0);
      pause();
      chk("req", 1'b0, cpu_irq_req_q);
      fire(21);
      rdchk("flag1", `VP_OFS_FLAG + 12'h4, 32'h0);
      $display("test single done");
      wr(`VP_OFS_PRIO + 12'h28, 32'h0040);
      wr(`VP_OFS_PRIO + 12'h3C, 32'h0400);
      wr(`VP_OFS_ENABLE + 12'h8, 32'h0200);
      wr(`VP_OFS_ENABLE + 12'hC, 32'h4000);
      fire(62);
      core(62, 3'h4);
      fire(41);
      core(41, 3'h4);
      wr(`VP_OFS_FLAG + 12'h8, 32'h0);
      pause();
      core(62, 3'h4);
      wr(`VP_OFS_FLAG + 12'hC, 32'h0);
      $display("test ties done");
      wr(`VP_OFS_PRIO + 12'h74, 32'h0030);
      fire(117);
      core(117, 3'h3);
      rdchk("flag7", `VP_OFS_FLAG + 12'h1C, 32'h0020);
      for (int l = 0; l < 8; l++)
      begin
         want_level <= 3'(l);
         pause();
         chk("req", l < 3, cpu_irq_req_q);
      end
      want_level <= 3'h0;
      want_hi <= 1'b1;
      pause();
      chk("req", 1'b0, cpu_irq_req_q);
      want_hi <= 1'b0;
      pause();
      chk("req", 1'b1, cpu_irq_req_q);
      $display("test levels done");
      // Vector hold: a better request must not move the latch until the core acks
      wr(`VP_OFS_PVS, 32'h2000);
      pause();
      fire(62);
      core(117, 3'h3);
      rdchk("pend", `VP_OFS_PVS, 32'hA37D);
      want_hi <= 1'b1;
      pause();
      want_hi <= 1'b0;
      repeat (4) pause();
      core(62, 3'h4);
      $display("test hold done");
      rdchk("status", `VP_OFS_IRQ_STATUS, 32'h1);
      chk("irq", 1'b0, irq_q);
      wr(`VP_OFS_IRQ_MASK, 32'h1);
      pause();
      chk("irq", 1'b1, irq_q);
      wr(`VP_OFS_IRQ_STATUS, 32'h1);
      pause();
      chk("irq", 1'b0, irq_q);
      $display("test interrupt done");
      trap_event <= 4'hF;
      soft_hard_trap_event <= 1'b1;
      double_bit_error_event <= 1'b1;
      @(posedge hclk);
      trap_event <= 4'h0;
      soft_hard_trap_event <= 1'b0;
      double_bit_error_event <= 1'b0;
      rdchk("ctl1", `VP_OFS_GC1, 32'h001E);
      rdchk("ctl4", `VP_OFS_GC4, 32'h3);
      wr(`VP_OFS_GC4, 32'h0);
      rdchk("ctl4", `VP_OFS_GC4, 32'h0);
      ext_irq_pin[0] <= 1'b1;
      pause();
      rdchk("flag0", `VP_OFS_FLAG, 32'h0001);
      wr(`VP_OFS_GC2, 32'h8002);
      rdchk("ctl2", `VP_OFS_GC2, 32'h8002);
      ext_irq_pin[1] <= 1'b1;
      pause();
      rdchk("flag1", `VP_OFS_FLAG + 12'h4, 32'h0);
      ext_irq_pin[1] <= 1'b0;
      pause();
      rdchk("flag1", `VP_OFS_FLAG + 12'h4, 32'h0010);
      wr(`VP_OFS_GC2, 32'h0002);
      pause();
      chk("req", 1'b0, cpu_irq_req_q);
      disi <= 1'b1;
      rdchk("ctl2", `VP_OFS_GC2, 32'h4002);
      $display("test control done");
      close_out();
   end
endmodule
